// ### hw/odr_diag_records.sv
// Parameter and diagnostic record bank of an eight-channel output module.
// Assumes the coupler presents one byte access per request, and that
// fault pins come asynchronously from the output driver stage.
`timescale 1ns/100ps
`default_nettype none
module odr_diag_records
	import odr_pkg::*;
#(
	parameter int unsigned CYCLES_PER_US = TICK_CYCLES
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire odr_req_s                req,
	output var  odr_rsp_s                rsp,
	input  wire logic                    system_stopped,
	input  wire odr_faults_s             faults_pin,
	input  wire logic                    aux_supply_missing_pin,
	input  wire logic                    module_failure_pin,
	input  wire logic                    internal_error_pin,
	input  wire logic                    int_comm_error_pin,
	output var  logic [NUM_CHANNELS-1:0] wire_break_detect_on,
	output var  logic [NUM_CHANNELS-1:0] short_detect_on,
	output var  logic                    diag_irq_pulse,
	output var  logic                    write_refused
);

	localparam int unsigned NC = NUM_CHANNELS;

	// Positions of the synchronised module-level pins inside misc_ff
	localparam int unsigned MP_AUX      = 0;
	localparam int unsigned MP_FAIL     = 1;
	localparam int unsigned MP_INTERNAL = 2;
	localparam int unsigned MP_COMM     = 3;

	// Module info never changes: digital class, channel info present
	localparam logic [7:0] MODULE_INFO_BYTE = 8'(MODULE_CLASS_DIGITAL) | (8'h01 << MI_CHAN_INFO);

	// Record decode used by the read path only
	function automatic logic is_full_diag(input odr_req_s r);
		return r.by_index ? (r.object_index == IDX_DIAG_FULL)
			: (r.record_set_number == REC_DIAG_FULL);
	endfunction

	function automatic logic is_short_diag(input odr_req_s r);
		return r.by_index ? (r.object_index == IDX_DIAG_SHORT)
			: (r.record_set_number == REC_DIAG_SHORT);
	endfunction

	// Parameter byte addressed by a write or a read, or an invalid marker
	function automatic logic [1:0] param_slot(input odr_req_s r);
		logic [1:0] s;
		s = 2'h3;
		if (r.by_index) begin
			if (r.byte_sel == PBYTE_DIAG_ENABLE) begin
				case (r.object_index)
					IDX_DIAG_ENABLE: s = 2'h0;
					IDX_WIRE_BREAK:  s = 2'h1;
					IDX_SHORT:       s = 2'h2;
					default:         s = 2'h3;
				endcase
			end
		end else if (r.record_set_number == REC_PARAM) begin
			case (r.byte_sel)
				PBYTE_DIAG_ENABLE: s = 2'h0;
				PBYTE_WIRE_BREAK:  s = 2'h1;
				PBYTE_SHORT:       s = 2'h2;
				default:           s = 2'h3;
			endcase
		end
		return s;
	endfunction

	// Parameter registers
	logic [7:0]    diag_interrupt_enable_ff;
	logic [NC-1:0] wire_break_detect_enable_ff;
	logic [NC-1:0] short_detect_enable_ff;
	logic          param_error_ff;

	// Synchronisers for asynchronous fault pins
	odr_faults_s   faults_meta_ff;
	odr_faults_s   faults_ff;
	logic [3:0]    misc_meta_ff;
	logic [3:0]    misc_ff;

	// Diagnostic state
	logic [7:0]    chan_err_ff [NC];
	logic [7:0]    module_error_primary_ff;
	logic [7:0]    module_error_secondary_ff;
	logic [31:0]   diag_timestamp_ff;
	logic [7:0]    prev_primary_ff;
	logic          diag_irq_ff;
	odr_rsp_s      rsp_ff;
	logic          refused_ff;

	logic [31:0]   us_count;
	logic [7:0]    nxt_primary;
	logic [7:0]    nxt_secondary;
	logic [NC-1:0] nxt_summary;
	logic [7:0]    nxt_chan_err [NC];
	logic          diag_event;
	logic          wr_hit;
	logic [1:0]    wslot;

	// Shared microsecond time base
	odr_us_ticker #(
		.CYCLES_PER_US (CYCLES_PER_US)
	) u_ticker (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.us_count (us_count)
	);

	// Two stages before any logic sees the driver-side fault levels
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			faults_meta_ff <= '0;
			faults_ff      <= '0;
			misc_meta_ff   <= '0;
			misc_ff        <= '0;
		end else begin
			faults_meta_ff <= faults_pin;
			faults_ff      <= faults_meta_ff;
			misc_meta_ff   <= {int_comm_error_pin, internal_error_pin,
				module_failure_pin, aux_supply_missing_pin};
			misc_ff        <= misc_meta_ff;
		end
	end

	// Write decode; writes outside the stopped state are dropped
	assign wslot  = param_slot(req);
	assign wr_hit = req.valid && req.write && (wslot != 2'h3) && system_stopped;

	// Parameter records keep their value until the next accepted write
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			diag_interrupt_enable_ff    <= RST_PARAM;
			wire_break_detect_enable_ff <= NC'(RST_PARAM);
			short_detect_enable_ff      <= NC'(RST_PARAM);
		end else if (wr_hit) begin
			case (wslot)
				2'h0: diag_interrupt_enable_ff <= req.wdata;
				2'h1: wire_break_detect_enable_ff <= req.wdata[NC-1:0];
				2'h2: short_detect_enable_ff <= req.wdata[NC-1:0];
				default: diag_interrupt_enable_ff <= diag_interrupt_enable_ff;
			endcase
		end
	end

	// Any interrupt enable value other than off or on is a parameterisation error
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			param_error_ff <= 1'b0;
		end else if (wr_hit && wslot == 2'h0) begin
			param_error_ff <= (req.wdata != DIAG_IRQ_OFF) && (req.wdata != DIAG_IRQ_ON);
		end
	end

	// Write refused while running: visible so the coupler can retry
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			refused_ff <= 1'b0;
		end else begin
			refused_ff <= req.valid && req.write && (wslot != 2'h3) && !system_stopped;
		end
	end

	// Per-channel detail bytes; detection faults only count when armed
	genvar ch;
	generate
		for (ch = 0; ch < NC; ch++) begin : g_chan
			always_comb begin
				nxt_chan_err[ch] = 8'h00;
				nxt_chan_err[ch][CE_CONFIG] = faults_ff.config_error[ch];
				nxt_chan_err[ch][CE_SHORT_SUPPLY] =
					faults_ff.short_supply[ch] && short_detect_enable_ff[ch];
				nxt_chan_err[ch][CE_SHORT_GROUND] =
					faults_ff.short_ground[ch] && short_detect_enable_ff[ch];
				nxt_chan_err[ch][CE_WIRE_BREAK] =
					faults_ff.wire_break[ch] && wire_break_detect_enable_ff[ch];
			end
			assign nxt_summary[ch] = |nxt_chan_err[ch];
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					chan_err_ff[ch] <= 8'h00;
				end else begin
					chan_err_ff[ch] <= nxt_chan_err[ch];
				end
			end
		end
	endgenerate

	// Module-level error bytes, reserved bits held at zero
	always_comb begin
		nxt_primary = 8'h00;
		nxt_primary[EA_MODULE_FAIL] = misc_ff[MP_FAIL];
		nxt_primary[EA_INTERNAL]    = misc_ff[MP_INTERNAL] || misc_ff[MP_COMM];
		nxt_primary[EA_EXTERNAL]    = misc_ff[MP_AUX] || (|nxt_summary);
		nxt_primary[EA_CHANNEL]     = |nxt_summary;
		nxt_primary[EA_AUX_MISSING] = misc_ff[MP_AUX];
		nxt_primary[EA_PARAM]       = param_error_ff;
		nxt_secondary = 8'h00;
		nxt_secondary[ED_INT_COMM]  = misc_ff[MP_COMM];
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			module_error_primary_ff   <= 8'h00;
			module_error_secondary_ff <= 8'h00;
		end else begin
			module_error_primary_ff   <= nxt_primary;
			module_error_secondary_ff <= nxt_secondary;
		end
	end

	// A diagnostic event is any newly raised primary error bit
	assign diag_event = |(module_error_primary_ff & ~prev_primary_ff);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prev_primary_ff <= 8'h00;
		end else begin
			prev_primary_ff <= module_error_primary_ff;
		end
	end

	// Timestamp is frozen at the event so a slow read stays coherent
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			diag_timestamp_ff <= 32'h0;
		end else if (diag_event) begin
			diag_timestamp_ff <= us_count;
		end
	end

	// Interrupt pulse only with the enable byte holding exactly on
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			diag_irq_ff <= 1'b0;
		end else begin
			diag_irq_ff <= diag_event && (diag_interrupt_enable_ff == DIAG_IRQ_ON);
		end
	end

	// Diagnostic record byte mux
	function automatic logic [7:0] diag_byte(input logic [4:0] b);
		logic [7:0] d;
		d = 8'h00;
		if (b >= DBYTE_CH_DETAIL0 && b < DBYTE_TIMESTAMP0) begin
			d = chan_err_ff[3'(b - DBYTE_CH_DETAIL0)];
		end else if (b >= DBYTE_TIMESTAMP0 && b <= DBYTE_FULL_LAST) begin
			d = diag_timestamp_ff[8*(2'(b - DBYTE_TIMESTAMP0)) +: 8];
		end else begin
			case (b)
				DBYTE_ERR_PRIMARY:   d = module_error_primary_ff;
				DBYTE_MODULE_INFO:   d = MODULE_INFO_BYTE;
				DBYTE_RESERVED_TWO:  d = 8'h00;
				DBYTE_ERR_SECONDARY: d = module_error_secondary_ff;
				DBYTE_CHANNEL_KIND:  d = {1'b0, CHANNEL_KIND_DOUT};
				DBYTE_BITS_PER_CH:   d = BITS_PER_CHANNEL;
				DBYTE_CHANNEL_COUNT: d = CHANNEL_COUNT_VAL;
				DBYTE_CH_SUMMARY:    d = summary_byte();
				default:             d = 8'h00;
			endcase
		end
		return d;
	endfunction

	// Summary rebuilt from stored detail bytes so both always agree
	function automatic logic [7:0] summary_byte();
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < NC; i++) begin
			s[i] = |chan_err_ff[i];
		end
		return s;
	endfunction

	// Parameter read-back through the parameter object indices
	function automatic logic [7:0] param_byte(input logic [1:0] s);
		case (s)
			2'h0:    return diag_interrupt_enable_ff;
			2'h1:    return 8'(wire_break_detect_enable_ff);
			2'h2:    return 8'(short_detect_enable_ff);
			default: return 8'h00;
		endcase
	endfunction

	// One-cycle answer; reads of record 00h show the short diagnostic view
	// Parameters read back only through the index path, never record 00h
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.valid <= req.valid;
			rsp_ff.error <= 1'b0;
			rsp_ff.rdata <= 8'h00;
			if (req.valid && req.write) begin
				rsp_ff.error <= (wslot == 2'h3) || !system_stopped;
			end else if (req.valid && is_full_diag(req)) begin
				rsp_ff.error <= req.byte_sel > DBYTE_FULL_LAST;
				rsp_ff.rdata <= diag_byte(req.byte_sel);
			end else if (req.valid && is_short_diag(req)) begin
				rsp_ff.error <= req.byte_sel > DBYTE_SHORT_LAST;
				if (req.byte_sel <= DBYTE_SHORT_LAST) begin
					rsp_ff.rdata <= diag_byte(req.byte_sel);
				end
			end else if (req.valid && wslot != 2'h3) begin
				rsp_ff.rdata <= param_byte(wslot);
			end else if (req.valid) begin
				rsp_ff.error <= 1'b1;
			end
		end
	end

	assign rsp                  = rsp_ff;
	assign wire_break_detect_on = wire_break_detect_enable_ff;
	assign short_detect_on      = short_detect_enable_ff;
	assign diag_irq_pulse       = diag_irq_ff;
	assign write_refused        = refused_ff;

endmodule
`default_nettype wire

// ### hw/odr_us_ticker.sv
// Free-running microsecond ticker for the diagnostic timestamp.
// Assumes ref_clk is steady from power-up and rst_n marks power-on.
`timescale 1ns/100ps
`default_nettype none
module odr_us_ticker
	import odr_pkg::*;
#(
	parameter int unsigned CYCLES_PER_US = TICK_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	output var  logic [31:0] us_count
);

	localparam int unsigned PW = $clog2(CYCLES_PER_US);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_US - 1);

	logic [PW-1:0] pre_ff;
	logic [31:0]   count_ff;

	// Prescaler divides the clock down to one step per microsecond
	always_ff @(posedge ref_clk) begin
		if (!rst_n || pre_ff == PRE_LAST) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= pre_ff + 1'b1;
		end
	end

	// Counter starts at zero, wraps silently at the 32-bit limit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_ff <= '0;
		end else if (pre_ff == PRE_LAST) begin
			count_ff <= count_ff + 32'h1;
		end
	end

	assign us_count = count_ff;

endmodule
`default_nettype wire

// ### inc/odr_pkg.sv
// Constants and carriers for the output module diagnostic record bank.
// Assumes a single 125 MHz clock and byte-wide record access.
`default_nettype none
package odr_pkg;

	// Clock and microsecond ticker timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_PERIOD_NS = 1000;
	localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Channel geometry
	localparam int unsigned NUM_CHANNELS = 8;
	localparam int unsigned DIAG_BYTES = 20;

	// Record set numbers
	localparam logic [7:0] REC_PARAM = 8'h00;
	localparam logic [7:0] REC_DIAG_SHORT = 8'h00;
	localparam logic [7:0] REC_DIAG_FULL = 8'h01;

	// Fieldbus object indices
	localparam logic [15:0] IDX_DIAG_ENABLE = 16'h3100;
	localparam logic [15:0] IDX_WIRE_BREAK = 16'h3101;
	localparam logic [15:0] IDX_SHORT = 16'h3102;
	localparam logic [15:0] IDX_DIAG_SHORT = 16'h2f00;
	localparam logic [15:0] IDX_DIAG_FULL = 16'h2f01;

	// Byte positions inside the parameter record
	localparam logic [4:0] PBYTE_DIAG_ENABLE = 5'h00;
	localparam logic [4:0] PBYTE_WIRE_BREAK = 5'h01;
	localparam logic [4:0] PBYTE_SHORT = 5'h02;

	// Byte positions inside the diagnostic record
	localparam logic [4:0] DBYTE_ERR_PRIMARY = 5'h00;
	localparam logic [4:0] DBYTE_MODULE_INFO = 5'h01;
	localparam logic [4:0] DBYTE_RESERVED_TWO = 5'h02;
	localparam logic [4:0] DBYTE_ERR_SECONDARY = 5'h03;
	localparam logic [4:0] DBYTE_CHANNEL_KIND = 5'h04;
	localparam logic [4:0] DBYTE_BITS_PER_CH = 5'h05;
	localparam logic [4:0] DBYTE_CHANNEL_COUNT = 5'h06;
	localparam logic [4:0] DBYTE_CH_SUMMARY = 5'h07;
	localparam logic [4:0] DBYTE_CH_DETAIL0 = 5'h08;
	localparam logic [4:0] DBYTE_TIMESTAMP0 = 5'h10;
	localparam logic [4:0] DBYTE_SHORT_LAST = 5'h03;
	localparam logic [4:0] DBYTE_FULL_LAST = 5'h13;

	// Parameter values and reset values
	localparam logic [7:0] DIAG_IRQ_OFF = 8'h00;
	localparam logic [7:0] DIAG_IRQ_ON = 8'h40;
	localparam logic [7:0] RST_PARAM = 8'h00;
	localparam logic [3:0] MODULE_CLASS_DIGITAL = 4'hf;
	localparam logic [6:0] CHANNEL_KIND_DOUT = 7'h72;
	localparam logic [7:0] BITS_PER_CHANNEL = 8'h08;
	localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h08;

	// Field positions of the primary module error byte
	localparam int unsigned EA_MODULE_FAIL = 0;
	localparam int unsigned EA_INTERNAL = 1;
	localparam int unsigned EA_EXTERNAL = 2;
	localparam int unsigned EA_CHANNEL = 3;
	localparam int unsigned EA_AUX_MISSING = 4;
	localparam int unsigned EA_PARAM = 7;
	// Field positions of module info, secondary error and channel detail
	localparam int unsigned MI_CHAN_INFO = 4;
	localparam int unsigned ED_INT_COMM = 4;
	localparam int unsigned CE_CONFIG = 0;
	localparam int unsigned CE_SHORT_SUPPLY = 2;
	localparam int unsigned CE_SHORT_GROUND = 3;
	localparam int unsigned CE_WIRE_BREAK = 4;

	// Record access request from the coupler side
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        by_index;
		logic [7:0]  record_set_number;
		logic [15:0] object_index;
		logic [4:0]  byte_sel;
		logic [7:0]  wdata;
	} odr_req_s;

	// Record access answer
	typedef struct packed {
		logic       valid;
		logic       error;
		logic [7:0] rdata;
	} odr_rsp_s;

	// Raw per-channel fault indications from the output drivers
	typedef struct packed {
		logic [NUM_CHANNELS-1:0] short_supply;
		logic [NUM_CHANNELS-1:0] short_ground;
		logic [NUM_CHANNELS-1:0] wire_break;
		logic [NUM_CHANNELS-1:0] config_error;
	} odr_faults_s;

endpackage
`default_nettype wire

// ### testbench/odr_coupler_model.sv
// Coupler model issuing one byte record access at a time.
// Assumes the bank answers each request one cycle after taking it.
`timescale 1ns/100ps
`default_nettype none
module odr_coupler_model
	import odr_pkg::*;
(
	input  wire logic     ref_clk,
	output var  odr_req_s req,
	input  wire odr_rsp_s rsp
);
	initial begin
		req = '0;
	end

	// Request held up to its taking edge, answer read while it stands
	task automatic xfer(input logic wr, input logic bi, input logic [7:0] rec,
		input logic [15:0] idx, input logic [4:0] bs, input logic [7:0] wd,
		output odr_rsp_s r);
		@(posedge ref_clk);
		#1;
		req = '{valid: 1'b1, write: wr, by_index: bi, record_set_number: rec,
			object_index: idx, byte_sel: bs, wdata: wd};
		@(posedge ref_clk);
		#1;
		// Scrambled after release so stale data never passes for fresh
		req.valid = 1'b0;
		req.wdata = ~wd;
		if (rsp.valid !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		r = rsp;
	endtask
endmodule
`default_nettype wire

// ### testbench/odr_diag_records_properties.sv
// Port-level checks for the record bank.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module odr_diag_records_properties
	import odr_pkg::*;
#(
	parameter int unsigned CYCLES_PER_US = TICK_CYCLES
) (
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	input wire odr_req_s                req,
	input wire odr_rsp_s                rsp,
	input wire logic                    system_stopped,
	input wire odr_faults_s             faults_pin,
	input wire logic                    aux_supply_missing_pin,
	input wire logic                    module_failure_pin,
	input wire logic                    internal_error_pin,
	input wire logic                    int_comm_error_pin,
	input wire logic [NUM_CHANNELS-1:0] wire_break_detect_on,
	input wire logic [NUM_CHANNELS-1:0] short_detect_on,
	input wire logic                    diag_irq_pulse,
	input wire logic                    write_refused
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Access shapes shared by several checks
	sequence s_rd(logic [7:0] rec, logic [4:0] b);
		req.valid && !req.write && !req.by_index && req.record_set_number == rec
			&& req.byte_sel == b;
	endsequence
	sequence s_wr(logic [4:0] b);
		req.valid && req.write && system_stopped && !req.by_index
			&& req.record_set_number == 8'h00 && req.byte_sel == b;
	endsequence
	// Both detections off long enough for the fault pipeline to drain
	sequence s_quiet;
		(wire_break_detect_on == 8'h00 && short_detect_on == 8'h00)[*4];
	endsequence

	chk_rsp_follows: assert property (req.valid |=> rsp.valid)
		else $error("request left unanswered");
	chk_no_stray_rsp: assert property (!req.valid |=> !rsp.valid)
		else $error("response without request");
	chk_refuse_running: assert property (req.valid && req.write && !system_stopped
		&& !req.by_index && req.record_set_number == 8'h00 && req.byte_sel < 5'h03
		|=> write_refused && rsp.error)
		else $error("parameter write while running not refused");
	chk_enables_frozen: assert property (req.valid && req.write && !system_stopped
		|=> $stable(wire_break_detect_on) && $stable(short_detect_on))
		else $error("enable changed by refused write");
	chk_wb_write: assert property (s_wr(5'h01) |=> wire_break_detect_on == $past(req.wdata))
		else $error("wire-break enable not taken");
	chk_short_write: assert property (s_wr(5'h02) |=> short_detect_on == $past(req.wdata))
		else $error("short enable not taken");
	chk_kind_const: assert property (s_rd(8'h01, 5'h04) |=> rsp.rdata == 8'h72 && !rsp.error)
		else $error("channel kind wrong");
	chk_count_consts: assert property (s_rd(8'h01, 5'h05) or s_rd(8'h01, 5'h06)
		|=> rsp.rdata == 8'h08)
		else $error("bit or channel count wrong");
	chk_aux_flag: assert property (aux_supply_missing_pin[*4] ##0 s_rd(8'h01, 5'h00)
		|=> rsp.rdata[4])
		else $error("aux supply flag missing");
	chk_detect_gated: assert property (s_quiet ##0 req.valid && !req.write
		&& !req.by_index && req.record_set_number == 8'h01 && req.byte_sel[4:3] == 2'b01
		|=> rsp.rdata[4:2] == 3'b000)
		else $error("detection error while disabled");
	chk_short_bound: assert property (req.valid && !req.write && !req.by_index
		&& req.record_set_number == 8'h00 && req.byte_sel > 5'h03 |=> rsp.error)
		else $error("short record read past byte 3");
endmodule

bind odr_diag_records odr_diag_records_properties #(.CYCLES_PER_US(CYCLES_PER_US)) u_props (
	.ref_clk, .rst_n, .req, .rsp, .system_stopped, .faults_pin, .aux_supply_missing_pin,
	.module_failure_pin, .internal_error_pin, .int_comm_error_pin, .wire_break_detect_on,
	.short_detect_on, .diag_irq_pulse, .write_refused
);
`default_nettype wire

// ### testbench/tb_odr_diag_records.sv
// Self-checking bench for the record bank.
// Assumes the coupler model and the bound property checker.
`timescale 1ns/100ps
`default_nettype none
module tb_odr_diag_records
	import odr_pkg::*;
;
	localparam int unsigned CPU = 4;
	localparam logic [7:0]  WB_EN = 8'h05;
	localparam logic [7:0]  SH_EN = 8'h30;
	logic        ref_clk, rst_n, system_stopped, diag_irq_pulse, write_refused;
	logic        aux_supply_missing_pin, module_failure_pin;
	logic        internal_error_pin, int_comm_error_pin;
	logic [7:0]  wire_break_detect_on, short_detect_on;
	odr_faults_s faults_pin;
	odr_req_s    req;
	odr_rsp_s    rsp, r;
	int          mismatches = 0, n_tests = 0, cyc = 0, irq_cnt = 0, rel0 = 0;

	odr_diag_records #(.CYCLES_PER_US(CPU)) dut (.ref_clk, .rst_n, .req, .rsp,
		.system_stopped, .faults_pin, .aux_supply_missing_pin, .module_failure_pin,
		.internal_error_pin, .int_comm_error_pin, .wire_break_detect_on,
		.short_detect_on, .diag_irq_pulse, .write_refused);
	odr_coupler_model cpl (.ref_clk, .req, .rsp);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Cycle count, interrupt pulses, and a ceiling well above the ~120-cycle run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (diag_irq_pulse === 1'b1) irq_cnt <= irq_cnt + 1;
		if (cyc == 3000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic rdf(input logic [4:0] bs);
		cpl.xfer(1'b0, 1'b0, 8'h01, 16'h0000, bs, 8'h00, r);
	endtask

	task automatic wrp(input logic bi, input logic [15:0] idx, input logic [4:0] bs,
		input logic [7:0] wd);
		cpl.xfer(1'b1, bi, 8'h00, idx, bs, wd, r);
	endtask

	task automatic t_after_reset();
		logic [7:0] exp [9] = '{8'h00, 8'h1f, 8'h00, 8'h00, 8'h72, 8'h08, 8'h08, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			rdf(5'(i));
			check_byte(r.rdata, exp[i], "record byte");
		end
		for (int i = 0; i < 4; i++) begin
			cpl.xfer(1'b0, 1'b0, 8'h00, 16'h0000, 5'(i), 8'h00, r);
			check_byte(r.rdata, exp[i], "short record");
			cpl.xfer(1'b0, 1'b1, 8'h00, 16'h2f00, 5'(i), 8'h00, r);
			check_byte(r.rdata, exp[i], "short index");
		end
		cpl.xfer(1'b0, 1'b1, 8'h00, 16'h2f01, 5'h04, 8'h00, r);
		check_byte(r.rdata, 8'h72, "full index");
		cpl.xfer(1'b0, 1'b1, 8'h00, 16'h2f00, 5'h04, 8'h00, r);
		check_byte({7'h00, r.error}, 8'h01, "short index bound");
		cpl.xfer(1'b0, 1'b0, 8'h00, 16'h0000, 5'h04, 8'h00, r);
		check_byte({7'h00, r.error}, 8'h01, "short record bound");
	endtask

	task automatic t_params();
		system_stopped = 1'b1;
		wrp(1'b0, 16'h0000, 5'h01, WB_EN);
		check_byte(wire_break_detect_on, WB_EN, "wire-break enable");
		wrp(1'b0, 16'h0000, 5'h02, SH_EN);
		check_byte(short_detect_on, SH_EN, "short enable");
		cpl.xfer(1'b0, 1'b1, 8'h00, 16'h3101, 5'h00, 8'h00, r);
		check_byte(r.rdata, WB_EN, "enable readback");
		wrp(1'b0, 16'h0000, 5'h00, 8'h41);
		@(posedge ref_clk);
		rdf(5'h00);
		check_byte(r.rdata, 8'h80, "bad interrupt enable");
		system_stopped = 1'b0;
		wrp(1'b0, 16'h0000, 5'h01, 8'hff);
		check_byte({6'h00, write_refused, r.error}, 8'h03, "write while running");
		check_byte(wire_break_detect_on, WB_EN, "enable kept");
	endtask

	task automatic t_faults();
		logic [31:0] ts;
		logic [31:0] exp_ts;
		system_stopped = 1'b1;
		wrp(1'b1, 16'h3100, 5'h00, 8'h40);
		system_stopped = 1'b0;
		faults_pin = '{short_supply: 8'h18, short_ground: 8'h20, wire_break: 8'hff,
			config_error: 8'h40};
		exp_ts = (cyc - rel0 + 4) / CPU;
		repeat (6) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			rdf(5'(8 + i));
			check_byte(r.rdata, {3'b000, WB_EN[i], SH_EN[i] & faults_pin.short_ground[i],
				SH_EN[i] & faults_pin.short_supply[i], 1'b0, faults_pin.config_error[i]},
				"channel detail");
		end
		rdf(5'h07);
		check_byte(r.rdata, 8'h75, "channel summary");
		rdf(5'h00);
		check_byte(r.rdata, 8'h0c, "primary on channel error");
		check_byte(8'(irq_cnt), 8'h01, "interrupt count");
		for (int i = 0; i < 4; i++) begin
			rdf(5'(16 + i));
			ts[8*i +: 8] = r.rdata;
		end
		check_byte({7'h00, ts + 2 >= exp_ts && ts <= exp_ts + 2}, 8'h01, "timestamp");
		faults_pin = '0;
	endtask

	task automatic t_module();
		system_stopped = 1'b1;
		wrp(1'b0, 16'h0000, 5'h00, 8'h00);
		wrp(1'b0, 16'h0000, 5'h01, 8'h00);
		wrp(1'b0, 16'h0000, 5'h02, 8'h00);
		system_stopped = 1'b0;
		faults_pin = '{short_supply: 8'hff, short_ground: 8'hff, wire_break: 8'hff,
			config_error: 8'h00};
		aux_supply_missing_pin = 1'b1;
		module_failure_pin = 1'b1;
		internal_error_pin = 1'b1;
		int_comm_error_pin = 1'b1;
		repeat (6) @(posedge ref_clk);
		rdf(5'h00);
		check_byte(r.rdata, 8'h17, "primary module errors");
		rdf(5'h03);
		check_byte(r.rdata, 8'h10, "secondary byte");
		rdf(5'h07);
		check_byte(r.rdata, 8'h00, "summary cleared");
		rdf(5'h0c);
		check_byte(r.rdata, 8'h00, "detection disarmed");
		check_byte(8'(irq_cnt), 8'h01, "interrupt masked");
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Reset for ten cycles, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		system_stopped = 1'b0;
		faults_pin = '0;
		aux_supply_missing_pin = 1'b0;
		module_failure_pin = 1'b0;
		internal_error_pin = 1'b0;
		int_comm_error_pin = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		rel0 = cyc;
		t_after_reset();
		t_params();
		t_faults();
		t_module();
		tally_and_finish();
	end
endmodule
`default_nettype wire
